/* hdl/asc_sequencer_control.sv */
// Design: converter sequencer control with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none

module asc_sequencer_control #(
  parameter int DEPTH = asc_pkg::QUEUE_DEPTH,
  parameter int CONV_DIV = asc_pkg::CONV_DIV_MIN
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [asc_pkg::AVS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [7:0] i_trig_int,
  input wire logic [7:0] i_trig_ext,
  input wire logic i_halt,
  input wire asc_pkg::asc_conv_rsp_t i_conv_rsp,
  output asc_pkg::asc_conv_req_t o_conv_req,
  output logic o_conv_clk,
  output logic o_power_down,
  output logic o_conv_irq,
  output logic o_wake_request
);
  import asc_pkg::*;

  // -------------------------------------------------------------------------
  // Local sizes
  // -------------------------------------------------------------------------
  localparam int PW = $clog2(DEPTH);
  // Never divide below the minimum, whatever the parameter asks for
  localparam int DIV = (CONV_DIV < CONV_DIV_MIN) ? CONV_DIV_MIN : CONV_DIV;
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [7:0] DIV_HALF = 8'(DIV / 2);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [5:0] RES_SPAN = 6'(2 * DEPTH);

  // -------------------------------------------------------------------------
  // Whole module state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic pd;
    logic circ;
    logic fmt;
    logic [2:0] opt;
    logic [2:0] irq_en;
    logic [7:0] dly;
    logic arm;
    logic [3:0] sel;
    logic eoc;
    logic sequence_done_flag;
    logic full_evt;
    logic stop_pend;
    asc_seq_state_t st;
    logic [7:0] dly_cnt;
    logic [1:0] ticks;
    logic [DEPTH-1:0][3:0] cmdq;
    logic [DEPTH-1:0][9:0] res;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] res_idx;
    logic [PW:0] count;
    logic [PW:0] seq_len;
    logic [7:0] div_cnt;
    logic conv_clk;
    logic pwr_down;
    logic ti1;
    logic ti2;
    logic te1;
    logic te2;
    logic te3;
    asc_conv_req_t req;
  } asc_regs_t;

  asc_regs_t q_reg;
  asc_regs_t q_next;

  // Result byte in the chosen alignment
  function automatic logic [7:0] asc_res_byte(input logic [9:0] v,
                                              input logic right,
                                              input logic hi);
    logic [7:0] b;
    b = 8'h00;
    if (right)
    begin
      b = hi ? {6'h00, v[9:8]} : v[7:0];
    end
    else
    begin
      b = hi ? v[9:2] : {v[1:0], 6'h00};
    end
    return b;
  endfunction

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb
  begin
    logic [4:0] idx;
    logic [4:0] ridx;
    logic [7:0] wb;
    logic [7:0] rb;
    logic wr_acc;
    logic sw_start;
    logic fire;
    logic push;
    logic pop;
    logic flush;
    logic full_hit;
    logic stop_now;
    logic plain;
    logic rise;
    logic [PW:0] idx_inc;
    idx = i_avs_address[6:2];
    ridx = 5'(idx - IDX_RES_BASE);
    wb = i_avs_writedata[7:0];
    rb = 8'h00;
    wr_acc = q_reg.ack & i_avs_write & i_avs_byteenable[0];
    sw_start = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    full_hit = 1'b0;
    stop_now = 1'b0;
    rise = 1'b0;
    fire = 1'b0;
    plain = ~q_reg.opt[OPT_AUTO_CLEAR] & ~(q_reg.circ & q_reg.opt[OPT_REPLAY]);
    idx_inc = (PW + 1)'(q_reg.res_idx) + (PW + 1)'(1);
    q_next = q_reg;
    q_next.req.sample = 1'b0;

    // One wait state per access; effects land on the accepting edge
    q_next.ack = (i_avs_read | i_avs_write) & ~q_reg.ack;

    // Conversion clock divider, limited to the maximum rate
    rise = (q_reg.div_cnt == DIV_LAST);
    q_next.div_cnt = rise ? 8'h00 : 8'(q_reg.div_cnt + 8'h01);
    q_next.conv_clk = (q_next.div_cnt < DIV_HALF);

    // Trigger sampling: external sources pass one extra stage
    q_next.ti1 = i_trig_int[q_reg.sel[2:0]];
    q_next.ti2 = q_reg.ti1;
    q_next.te1 = i_trig_ext[q_reg.sel[2:0]];
    q_next.te2 = q_reg.te1;
    q_next.te3 = q_reg.te2;
    fire = q_reg.arm & (q_reg.sel[TRIG_SEL_EXT] ? (q_reg.te2 & ~q_reg.te3)
                                               : (q_reg.ti1 & ~q_reg.ti2));

    // Register writes
    if (wr_acc)
    begin
      case (idx)
        IDX_CFG:
        begin
          q_next.pd = wb[CFG_PD];
          q_next.circ = wb[CFG_CIRC];
          q_next.fmt = wb[CFG_FMT];
          flush = wb[CFG_CLEAR];
          if (wb[CFG_STOP])
          begin
            q_next.arm = 1'b0;
            if (q_reg.opt[OPT_ENH_ABORT])
            begin
              q_next.stop_pend = 1'b1;
            end
            else
            begin
              stop_now = 1'b1;
            end
          end
        end
        IDX_START: sw_start = wb[START_BIT];
        IDX_IRQ_EN: q_next.irq_en = wb[2:0];
        IDX_CMDQ:
        begin
          // Entries beyond the depth are dropped and flagged
          if (q_reg.count == FULL_CNT)
          begin
            full_hit = 1'b1;
          end
          else
          begin
            push = 1'b1;
          end
        end
        IDX_STATUS:
        begin
          // Write-one-to-clear; sequencer sets below win
          if (wb[ST_EOC])
          begin
            q_next.eoc = 1'b0;
          end
          if (wb[ST_EOS])
          begin
            q_next.sequence_done_flag = 1'b0;
          end
        end
        IDX_DELAY: q_next.dly = wb;
        IDX_TRIG:
        begin
          q_next.arm = wb[TRIG_ARM];
          q_next.sel = wb[TRIG_SEL_LSB +: 4];
        end
        IDX_OPT: q_next.opt = wb[2:0];
        default: ;
      endcase
    end

    // Sequencer
    case (q_reg.st)
      SEQ_IDLE:
      begin
        // Start needs the power-down bit clear and a non-empty queue
        if ((sw_start | fire) & ~q_reg.pd & (q_reg.count != '0)
            & ~q_reg.stop_pend)
        begin
          q_next.st = SEQ_DELAY;
          q_next.dly_cnt = q_reg.dly;
          q_next.arm = 1'b0;
          if (~plain)
          begin
            q_next.res_idx = '0;
          end
        end
      end
      SEQ_DELAY:
      begin
        // Holds delay + 1 master periods
        if (q_reg.dly_cnt == 8'h00)
        begin
          q_next.st = SEQ_ALIGN;
          q_next.ticks = 2'h0;
        end
        else
        begin
          q_next.dly_cnt = 8'(q_reg.dly_cnt - 8'h01);
        end
      end
      SEQ_ALIGN:
      begin
        // Converter-clock sync plus two converter periods
        if (rise)
        begin
          if (q_reg.ticks == CONV_SYNC_TICKS - 2'h1)
          begin
            q_next.req.sample = 1'b1;
            q_next.req.gain = q_reg.cmdq[q_reg.rd_ptr][3];
            q_next.req.channel = q_reg.cmdq[q_reg.rd_ptr][2:0];
            q_next.st = SEQ_CONVERT;
          end
          else
          begin
            q_next.ticks = 2'(q_reg.ticks + 2'h1);
          end
        end
      end
      SEQ_CONVERT:
      begin
        if (i_conv_rsp.valid)
        begin
          q_next.res[q_reg.res_idx] = i_conv_rsp.data;
          q_next.eoc = 1'b1;
          // Result index wraps within the programmed length
          q_next.res_idx = (idx_inc >= q_reg.seq_len) ? '0
                                                      : idx_inc[PW-1:0];
          q_next.rd_ptr = PW'(q_reg.rd_ptr + 1'b1);
          q_next.st = SEQ_ALIGN; // later entries skip the delay
          q_next.ticks = 2'h0;
          if (~q_reg.circ)
          begin
            // Single mode consumes the entry, which frees the queue
            pop = 1'b1;
            if (q_reg.count == (PW + 1)'(1))
            begin
              q_next.sequence_done_flag = 1'b1;
              q_next.st = SEQ_IDLE;
              flush = flush | q_reg.opt[OPT_AUTO_CLEAR];
            end
          end
          else if ((PW + 1)'(q_reg.rd_ptr) == q_reg.seq_len - 1'b1)
          begin
            // Wrap to the first entry; replay stops, continuous runs on
            q_next.sequence_done_flag = 1'b1;
            q_next.rd_ptr = '0;
            q_next.res_idx = '0;
            q_next.st = q_reg.opt[OPT_REPLAY] ? SEQ_IDLE : SEQ_ALIGN;
          end
        end
      end
      default: q_next.st = SEQ_IDLE;
    endcase

    // Enhanced stop waits out a running conversion, then clears
    if (q_reg.stop_pend & ((q_reg.st != SEQ_CONVERT) | i_conv_rsp.valid))
    begin
      stop_now = 1'b1;
      flush = 1'b1;
      q_next.stop_pend = 1'b0;
    end
    if (stop_now)
    begin
      q_next.st = SEQ_IDLE;
      q_next.req.sample = 1'b0;
    end

    // Queue bookkeeping
    if (push)
    begin
      q_next.cmdq[q_reg.wr_ptr] = wb[3:0];
      q_next.wr_ptr = PW'(q_reg.wr_ptr + 1'b1);
      q_next.seq_len = (PW + 1)'(q_reg.seq_len + 1'b1);
    end
    q_next.count = (PW + 1)'(q_reg.count + (PW + 1)'(push)
                             - (PW + 1)'(pop));
    if (flush)
    begin
      // Both pointers back to the first entry
      q_next.wr_ptr = '0;
      q_next.rd_ptr = '0;
      q_next.res_idx = '0;
      q_next.count = '0;
      q_next.seq_len = '0;
    end
    // Full event lasts only while the queue stays full
    q_next.full_evt = (q_reg.full_evt & (q_next.count == FULL_CNT))
                      | full_hit;

    // Halt overrides the power-down bit
    q_next.pwr_down = q_next.pd | i_halt;

    // Read data captured at the end of the wait state, one edge before the accepting edge
    case (idx)
      IDX_CFG: rb = {3'h0, q_reg.fmt, q_reg.circ, 1'b0, q_reg.stop_pend,
                     q_reg.pd};
      IDX_IRQ_EN: rb = {5'h00, q_reg.irq_en};
      IDX_STATUS: rb = {3'h0, q_reg.stop_pend, q_reg.st != SEQ_IDLE,
                        q_reg.full_evt, q_reg.sequence_done_flag, q_reg.eoc};
      IDX_DELAY: rb = q_reg.dly;
      IDX_TRIG: rb = {3'h0, q_reg.sel, q_reg.arm};
      IDX_OPT: rb = {5'h00, q_reg.opt};
      default:
      begin
        if ((idx >= IDX_RES_BASE) && ({1'b0, ridx} < RES_SPAN))
        begin
          rb = asc_res_byte(q_reg.res[ridx[PW:1]], q_reg.fmt, ridx[0]);
        end
      end
    endcase
    q_next.rdata = q_next.ack ? {24'h000000, rb} : q_reg.rdata;
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      q_reg <= '0;
      q_reg.pd <= CFG_RESET[CFG_PD];
      q_reg.pwr_down <= CFG_RESET[CFG_PD];
      // Divider restarts at a full high phase, so no short first pulse
      q_reg.div_cnt <= DIV_LAST;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  // Waitrequest drops one cycle after the request appears
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~q_reg.ack;
  assign o_avs_readdata = q_reg.rdata;
  assign o_conv_req = q_reg.req;
  assign o_conv_clk = q_reg.conv_clk;
  assign o_power_down = q_reg.pwr_down;
  // Each source gated by its own enable
  assign o_conv_irq = |({q_reg.full_evt, q_reg.sequence_done_flag, q_reg.eoc}
                        & q_reg.irq_en);
  // Done events double as wake-up from sleep-until-interrupt
  assign o_wake_request = (q_reg.eoc & q_reg.irq_en[IRQ_EOC])
                          | (q_reg.sequence_done_flag & q_reg.irq_en[IRQ_EOS]);

endmodule // asc_sequencer_control

`default_nettype wire

/* common/asc_pkg.sv */
// Package: constants and carrier types of the converter sequencer control
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`default_nettype none

package asc_pkg;

  // -------------------------------------------------------------------------
  // Bus geometry and register word indexes (byte address = 4 * index)
  // -------------------------------------------------------------------------
  localparam int AVS_ADDR_W = 7;
  localparam logic [4:0] IDX_CFG = 5'h00;
  localparam logic [4:0] IDX_START = 5'h01;
  localparam logic [4:0] IDX_IRQ_EN = 5'h02;
  localparam logic [4:0] IDX_CMDQ = 5'h03;
  localparam logic [4:0] IDX_RES_BASE = 5'h04;
  localparam logic [4:0] IDX_STATUS = 5'h14;
  localparam logic [4:0] IDX_DELAY = 5'h15;
  localparam logic [4:0] IDX_TRIG = 5'h16;
  localparam logic [4:0] IDX_OPT = 5'h17;

  // -------------------------------------------------------------------------
  // Field positions and reset values
  // -------------------------------------------------------------------------
  localparam int CFG_PD = 0;
  localparam int CFG_STOP = 1;
  localparam int CFG_CLEAR = 2;
  localparam int CFG_CIRC = 3;
  localparam int CFG_FMT = 4;
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam int START_BIT = 0;
  localparam int IRQ_EOC = 0;
  localparam int IRQ_EOS = 1;
  localparam int IRQ_FULL = 2;
  localparam int ST_EOC = 0;
  localparam int ST_EOS = 1;
  localparam int ST_FULL = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_STOP_PEND = 4;
  localparam int OPT_AUTO_CLEAR = 0;
  localparam int OPT_REPLAY = 1;
  localparam int OPT_ENH_ABORT = 2;
  localparam int TRIG_ARM = 0;
  localparam int TRIG_SEL_LSB = 1;
  localparam int TRIG_SEL_EXT = 3;

  // -------------------------------------------------------------------------
  // Sizes and timing
  // -------------------------------------------------------------------------
  localparam int QUEUE_DEPTH = 8;
  localparam int MCLK_HZ = 25_000_000;
  localparam int CONV_MAX_HZ = 6_000_000;
  localparam int CONV_DIV_MIN = (MCLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
  localparam logic [1:0] CONV_SYNC_TICKS = 2'h3;

  // -------------------------------------------------------------------------
  // Sequencer states and converter carriers
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_ALIGN, SEQ_CONVERT}
    asc_seq_state_t;

  typedef struct packed {
    logic sample;
    logic gain;
    logic [2:0] channel;
  } asc_conv_req_t;

  typedef struct packed {
    logic valid;
    logic [9:0] data;
  } asc_conv_rsp_t;

endpackage

`default_nettype wire

/* dv/asc_props.sv */
// Checker: timing relations at the sequencer control ports
`timescale 1ns/1ps
`default_nettype none

module asc_props #(
  parameter int CONV_DIV = 5
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [asc_pkg::AVS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [7:0] i_trig_int,
  input wire logic [7:0] i_trig_ext,
  input wire logic i_halt,
  input wire asc_pkg::asc_conv_rsp_t i_conv_rsp,
  input wire asc_pkg::asc_conv_req_t o_conv_req,
  input wire logic o_conv_clk,
  input wire logic o_power_down,
  input wire logic o_conv_irq,
  input wire logic o_wake_request
);
  import asc_pkg::*;
  logic acc, st, tr, sw_first, any_first;
  logic [7:0] dly;
  int cnt, gap;

  // Accepted writes to start and trigger words
  assign acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign st = acc && i_avs_address[6:2] == IDX_START;
  assign tr = acc && i_avs_address[6:2] == IDX_TRIG;

  // Delay copy, cycles since start, cycles since last result
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      dly <= 8'h00;
      sw_first <= 1'b0;
      any_first <= 1'b1;
      cnt <= 0;
      gap <= 0;
    end
    else
    begin
      if (acc && i_avs_address[6:2] == IDX_DELAY)
        dly <= i_avs_writedata[7:0];
      cnt <= st ? 0 : cnt + 1;
      gap <= i_conv_rsp.valid ? 0 : gap + 1;
      sw_first <= st ? 1'b1 : (tr || o_conv_req.sample) ? 1'b0 : sw_first;
      any_first <= (st || tr) ? 1'b1 : o_conv_req.sample ? 1'b0 : any_first;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  a_conv_rate:
    assert property ($rose(o_conv_clk) |=> (!$rose(o_conv_clk)) [*4])
    else $error("conversion clock too fast");
  a_start_latency:
    assert property (o_conv_req.sample && sw_first |->
      cnt >= dly + 1 + 2 * CONV_DIV && cnt <= dly + 4 + 3 * CONV_DIV)
    else $error("first sample at wrong time");
  a_no_redelay:
    assert property (o_conv_req.sample && !any_first |->
      gap <= 3 * CONV_DIV + 3)
    else $error("later sample delayed");
  a_halt_pd:
    assert property (i_halt |=> o_power_down)
    else $error("halt left converter powered");
  a_pd_no_sample:
    assert property (o_power_down |-> !o_conv_req.sample)
    else $error("sample while powered down");
  a_wake_irq:
    assert property (o_wake_request |-> o_conv_irq)
    else $error("wake without interrupt");
  a_sample_pulse:
    assert property (o_conv_req.sample |=> !o_conv_req.sample)
    else $error("sample pulse too long");
  a_bus_wait:
    assert property ($rose(i_avs_read || i_avs_write) |->
      o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not after one wait state");
endmodule // asc_props

`default_nettype wire

/* dv/asc_conv_model.sv */
// Behavioural model of the analog converter macro
`timescale 1ns/1ps
`default_nettype none

module asc_conv_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire asc_pkg::asc_conv_req_t i_req,
  input wire logic i_pd,
  input wire logic [3:0] i_lat,
  output var asc_pkg::asc_conv_rsp_t o_rsp,
  output var int o_count
);
  import asc_pkg::*;
  logic [3:0] wait_cnt;
  logic [9:0] held;

  // Answer each sample after i_lat cycles; data toggles when not valid
  always @(posedge i_mclk)
  begin
    o_rsp.valid <= 1'b0;
    o_rsp.data <= ~o_rsp.data; // Stale data must never pass as a result
    if (i_reset)
    begin
      o_rsp <= '0;
      wait_cnt <= 4'h0;
      o_count <= 0;
    end
    else if (i_req.sample && !i_pd) // Powered-down macro stays silent
    begin
      o_count <= o_count + 1; // One count per accepted sample request
      held <= {i_req.channel, i_req.gain, i_req.channel, i_req.gain, 2'b01};
      wait_cnt <= i_lat;
    end
    else if (wait_cnt == 4'h1)
    begin
      o_rsp.valid <= 1'b1;
      o_rsp.data <= held;
      wait_cnt <= 4'h0;
    end
    else if (wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
  end
endmodule // asc_conv_model

`default_nettype wire

/* dv/testbench.sv */
// Testbench: register scenarios against the converter model
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import asc_pkg::*;
  typedef struct {logic [7:0] e; logic [7:0] m; string n;} asc_chk_t;
  localparam int CDIV = 5;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic halt = 1'b0;
  logic [6:0] adr = 7'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] t_int = 8'h00;
  logic [7:0] t_ext = 8'h00;
  logic [3:0] lat = 4'h1;
  logic [31:0] rdata;
  logic wt, pd, irq;
  logic [3:0] ch[8];
  logic [7:0] dly, rd_last;
  logic [9:0] d;
  logic [2:0] s;
  asc_conv_rsp_t rsp;
  asc_conv_req_t req;
  asc_chk_t q[$];
  asc_chk_t c;
  int nsamp, n, t0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  asc_sequencer_control #(.CONV_DIV(CDIV)) i_asc_sequencer_control (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_avs_address(adr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_byteenable(4'h1),
    .i_avs_writedata({24'h0, wd}), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wt), .i_trig_int(t_int), .i_trig_ext(t_ext),
    .i_halt(halt), .i_conv_rsp(rsp), .o_conv_req(req), .o_conv_clk(),
    .o_power_down(pd), .o_conv_irq(irq), .o_wake_request());
  asc_conv_model i_asc_conv_model (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_req(req), .i_pd(pd),
    .i_lat(lat), .o_rsp(rsp), .o_count(nsamp));

  // Clock and hang guard
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // Read watcher: oldest note against each accepted read
  always @(negedge i_mclk)
  begin
    if (rd_s && !wt)
    begin
      c = q.pop_front();
      rd_last = rdata[7:0];
      tests_run++;
      if ((rdata & {24'hffffff, c.m}) !== {24'h0, c.e & c.m})
      begin
        $display("BAD %s expected %h seen %h", c.n, c.e, rdata);
        n_fail++;
      end
    end
  end

  // Bus cycle held until waitrequest is seen low at a falling edge
  task automatic bus(input logic w, input logic [4:0] ix, input logic [7:0] v);
    logic busy;
    @(posedge i_mclk);
    adr <= {ix, 2'b00};
    wd <= v;
    wr_s <= w;
    rd_s <= !w;
    do
    begin
      @(negedge i_mclk);
      busy = wt;
      @(posedge i_mclk);
    end
    while (busy);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    // Return mid-cycle so callers see the settled result of the access
    @(negedge i_mclk);
  endtask

  task automatic rd(input logic [4:0] ix, input logic [7:0] e, m, string nm);
    q.push_back('{e, m, nm});
    bus(1'b0, ix, 8'h00);
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string nm);
    @(negedge i_mclk);
    tests_run++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'he56bc640));
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd(IDX_CFG, CFG_RESET, 8'hff, "cfg");
    rd(IDX_STATUS, 8'h00, 8'hff, "status");
    bus(1'b1, 5'h1f, 8'h5a);
    rd(5'h1f, 8'h00, 8'hff, "unmapped");
    $display("test reset done");
    bus(1'b1, IDX_CMDQ, 8'h02);
    bus(1'b1, IDX_START, 8'h01);
    bus(1'b1, IDX_CFG, 8'h14);
    repeat (750) @(posedge i_mclk);
    bus(1'b1, IDX_START, 8'h01);
    repeat (60) @(posedge i_mclk);
    chk(nsamp, 0, "samples");
    $display("test ignored start done");
    bus(1'b1, IDX_OPT, 8'h01);
    bus(1'b1, IDX_IRQ_EN, 8'h02);
    dly = 8'($urandom_range(20, 1));
    bus(1'b1, IDX_DELAY, dly);
    n = $urandom_range(8, 2);
    lat <= 4'($urandom_range(6, 1));
    for (int k = 0; k < n; k++)
    begin
      ch[k] = 4'($urandom);
      bus(1'b1, IDX_CMDQ, {4'h0, ch[k]});
    end
    bus(1'b1, IDX_START, 8'h01);
    for (int k = 0; irq !== 1'b1 && k < 3000; k++)
      @(negedge i_mclk);
    for (int k = 0; k < n; k++)
    begin
      d = {ch[k][2:0], ch[k][3], ch[k][2:0], ch[k][3], 2'b01};
      rd(IDX_RES_BASE + 5'(2 * k), d[7:0], 8'hff, "res_low");
      rd(IDX_RES_BASE + 5'(2 * k + 1), {6'h0, d[9:8]}, 8'hff, "res_high");
    end
    rd(IDX_STATUS, 8'h03, 8'h1f, "status");
    bus(1'b1, IDX_IRQ_EN, 8'h00);
    chk(irq, 1'b0, "irq");
    bus(1'b1, IDX_IRQ_EN, 8'h02);
    chk(irq, 1'b1, "irq");
    bus(1'b1, IDX_STATUS, 8'h00);
    rd(IDX_STATUS, 8'h03, 8'h07, "status");
    bus(1'b1, IDX_STATUS, 8'h02);
    rd(IDX_STATUS, 8'h01, 8'h07, "status");
    chk(irq, 1'b0, "irq");
    $display("test single sequence done");
    bus(1'b1, IDX_OPT, 8'h00);
    bus(1'b1, IDX_IRQ_EN, 8'h04);
    for (int k = 0; k < 9; k++)
      bus(1'b1, IDX_CMDQ, 8'h07);
    rd(IDX_STATUS, 8'h04, 8'h04, "full");
    bus(1'b1, IDX_START, 8'h01);
    for (int k = 0; irq === 1'b1 && k < 500; k++)
      @(negedge i_mclk);
    rd(IDX_STATUS, 8'h00, 8'h04, "full");
    bus(1'b1, IDX_CFG, 8'h12);
    rd(IDX_CFG, 8'h00, 8'h02, "stop");
    repeat (100) @(posedge i_mclk);
    bus(1'b1, IDX_STATUS, 8'h03);
    for (int k = 0; k < 3; k++)
      bus(1'b1, IDX_CMDQ, 8'h01);
    bus(1'b1, IDX_CFG, 8'h14);
    rd(IDX_STATUS, 8'h00, 8'h04, "full");
    $display("test queue full done");
    bus(1'b1, IDX_OPT, 8'h04);
    bus(1'b1, IDX_CFG, 8'h1c);
    bus(1'b1, IDX_CMDQ, 8'h03);
    bus(1'b1, IDX_CMDQ, 8'h0c);
    n = nsamp;
    bus(1'b1, IDX_START, 8'h01);
    for (int k = 0; nsamp < n + 6 && k < 2000; k++)
      @(posedge i_mclk);
    chk(32'(nsamp >= n + 6), 1, "rounds");
    bus(1'b1, IDX_CFG, 8'h1a);
    for (int k = 0; k < 40; k++)
    begin
      rd(IDX_CFG, 8'h00, 8'h00, "poll");
      if (rd_last[1] === 1'b0)
        break;
    end
    chk(rd_last[1], 1'b0, "stop");
    bus(1'b1, IDX_STATUS, 8'h03);
    n = nsamp;
    bus(1'b1, IDX_START, 8'h01);
    repeat (200) @(posedge i_mclk);
    chk(nsamp, n, "samples");
    $display("test continuous abort done");
    bus(1'b1, IDX_OPT, 8'h02);
    for (int r = 0; r < 2; r++)
    begin
      bus(1'b1, IDX_CFG, 8'h1c);
      bus(1'b1, IDX_CMDQ, 8'h09);
      bus(1'b1, IDX_CMDQ, 8'h06);
      n = nsamp;
      bus(1'b1, IDX_START, 8'h01);
      repeat (150) @(posedge i_mclk);
      chk(nsamp, n + 2, "replay_count");
      rd(IDX_STATUS, 8'h02, 8'h0a, "replay_idle");
      rd(IDX_RES_BASE, 8'hcd, 8'hff, "replay_res");
    end
    $display("test replay done");
    bus(1'b1, IDX_OPT, 8'h00);
    for (int e = 0; e < 2; e++)
    begin
      s = 3'($urandom);
      bus(1'b1, IDX_CFG, 8'h14);
      bus(1'b1, IDX_CMDQ, 8'h05);
      bus(1'b1, IDX_TRIG, {3'h0, e[0], s, 1'b1});
      n = nsamp;
      t_int[s] <= !e[0];
      t_ext[s] <= e[0];
      t0 = cyc;
      for (int k = 0; nsamp == n && k < 300; k++)
        @(posedge i_mclk);
      t0 = cyc - t0;
      t_int <= 8'h00;
      t_ext <= 8'h00;
      chk(32'(t0 >= dly + 2 + 2 * CDIV && t0 <= dly + 10 + 3 * CDIV),
        1, "trig_latency");
      rd(IDX_TRIG, 8'h00, 8'h01, "arm");
      rd(IDX_RES_BASE, 8'ha9, 8'hff, "trig_res");
    end
    $display("test trigger done");
    halt <= 1'b1;
    @(negedge i_mclk);
    chk(pd, 1'b1, "power_down");
    @(posedge i_mclk);
    halt <= 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(pd, 1'b0, "power_down");
    bus(1'b1, IDX_TRIG, 8'h00);
    bus(1'b1, IDX_CFG, 8'h05);
    chk(pd, 1'b1, "pd_bit");
    $display("test halt done");
    finish_test();
  end
endmodule // testbench

bind asc_sequencer_control asc_props #(.CONV_DIV(CONV_DIV)) i_asc_props (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_trig_int(i_trig_int), .i_trig_ext(i_trig_ext), .i_halt(i_halt),
  .i_conv_rsp(i_conv_rsp), .o_conv_req(o_conv_req),
  .o_conv_clk(o_conv_clk), .o_power_down(o_power_down),
  .o_conv_irq(o_conv_irq), .o_wake_request(o_wake_request));

`default_nettype wire
